// [src/cvd_i2c_port.sv]
// Two-wire slave port for the common voltage setting byte
`timescale 1ns/100ps
`default_nettype none
`include "cvd_defines.svh"
module cvd_i2c_port (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  output logic      [6:0] common_voltage_code,
  output logic            nv_write_busy
);

  cvd_pkg::cvd_port_s port_q;
  cvd_pkg::cvd_port_s port_d;

  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic       addr_hit;
  logic [6:0] nv_code;
  logic       nv_busy;
  logic [7:0] rd_byte;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Last of the eight bit slots of a byte
  function automatic logic last_slot(input logic [2:0] cnt);
    last_slot = (cnt == 3'h7);
  endfunction

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  cvd_nv_store u_nv (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .wr_req  (port_q.nv_req),
    .wr_data (port_q.dac),
    .nv_code (nv_code),
    .nv_busy (nv_busy)
  );

  // ------------------------------------------------------------
  // Bus conditions
  // ------------------------------------------------------------
  // oversampled edges, bus rate well below ref_clk
  assign scl_rise  = scl_i && !port_q.scl_q;
  assign scl_fall  = !scl_i && port_q.scl_q;
  assign bus_start = scl_i && port_q.scl_q && port_q.sda_q && !sda_i;
  assign bus_stop  = scl_i && port_q.scl_q && !port_q.sda_q && sda_i;
  assign addr_hit  = (port_q.sh[7:1] == `CVD_SLAVE_ADDR);
  assign rd_byte   = cvd_pkg::cvd_read_byte(port_q.dac, nv_code);

  // ------------------------------------------------------------
  // Transfer sequencer
  // ------------------------------------------------------------
  always_comb begin
    port_d        = port_q;
    port_d.scl_q  = scl_i;
    port_d.sda_q  = sda_i;
    port_d.nv_req = 1'b0;
    port_d.boot   = 1'b0;
    if (port_q.boot) begin
      port_d.dac = nv_code;
    end
    if (bus_start) begin
      port_d.st     = cvd_pkg::ST_ADDR;
      port_d.cnt    = 3'h0;
      port_d.sda_oe = 1'b0;
    end else if (bus_stop) begin
      port_d.st     = cvd_pkg::ST_IDLE;
      port_d.sda_oe = 1'b0;
    end else begin
      case (port_q.st)
        cvd_pkg::ST_ADDR, cvd_pkg::ST_WR: begin
          if (scl_rise) begin
            port_d.sh  = {port_q.sh[6:0], sda_i};
            port_d.cnt = port_q.cnt + 3'h1;
            if (last_slot(port_q.cnt)) begin
              port_d.st = (port_q.st == cvd_pkg::ST_ADDR) ? cvd_pkg::ST_ADDR_END : cvd_pkg::ST_WR_END;
            end
          end
        end
        cvd_pkg::ST_ADDR_END: begin
          if (scl_fall) begin
            port_d.rw = port_q.sh[0];
            if (addr_hit && !nv_busy) begin
              port_d.st     = cvd_pkg::ST_ACK_A;
              port_d.sda_oe = 1'b1;
            end else begin
              port_d.st = cvd_pkg::ST_IGNORE;
            end
          end
        end
        cvd_pkg::ST_ACK_A: begin
          if (scl_fall) begin
            port_d.cnt = 3'h0;
            if (port_q.rw) begin
              port_d.sh     = rd_byte;
              port_d.sda_oe = !rd_byte[7];
              port_d.st     = cvd_pkg::ST_RD;
            end else begin
              port_d.sda_oe = 1'b0;
              port_d.st     = cvd_pkg::ST_WR;
            end
          end
        end
        cvd_pkg::ST_WR_END: begin
          if (scl_fall) begin
            port_d.dac    = port_q.sh[`CVD_CODE_MSB:`CVD_CODE_LSB];
            port_d.nv_req = !port_q.sh[`CVD_DEST_BIT];
            port_d.sda_oe = 1'b1;
            port_d.st     = cvd_pkg::ST_ACK_W;
          end
        end
        cvd_pkg::ST_ACK_W: begin
          if (scl_fall) begin
            port_d.sda_oe = 1'b0;
            port_d.st     = cvd_pkg::ST_IGNORE;
          end
        end
        cvd_pkg::ST_RD: begin
          if (scl_fall) begin
            port_d.cnt = port_q.cnt + 3'h1;
            if (last_slot(port_q.cnt)) begin
              port_d.sda_oe = 1'b0;
              port_d.st     = cvd_pkg::ST_IGNORE;
            end else begin
              port_d.sh     = {port_q.sh[6:0], 1'b0};
              port_d.sda_oe = !port_q.sh[6];
            end
          end
        end
        cvd_pkg::ST_IDLE, cvd_pkg::ST_IGNORE: begin
          port_d.st = port_q.st;
        end
        default: begin
          port_d.st     = cvd_pkg::ST_IDLE;
          port_d.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      port_q <= '{st: cvd_pkg::ST_IDLE, cnt: 3'h0, sh: 8'h00, rw: 1'b0, sda_oe: 1'b0,
                  scl_q: 1'b1, sda_q: 1'b1, dac: `CVD_NV_RESET, boot: 1'b1, nv_req: 1'b0};
    end else begin
      port_q <= port_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // open drain, pulls low only
  assign sda_o               = 1'b0;
  assign sda_oe              = port_q.sda_oe;
  assign common_voltage_code = port_q.dac;
  assign nv_write_busy       = nv_busy;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  logic quiet;
  assign quiet = scl_fall && !bus_start && !bus_stop;

  a_addr_ack_hit: assert property (port_q.st == cvd_pkg::ST_ADDR_END && quiet && addr_hit && !nv_busy |=> port_q.sda_oe && port_q.st == cvd_pkg::ST_ACK_A)
    else $error("own address not acknowledged");
  a_busy_ignores: assert property (port_q.st == cvd_pkg::ST_ADDR_END && quiet && nv_busy |=> port_q.st == cvd_pkg::ST_IGNORE && !port_q.sda_oe)
    else $error("address answered during storage write");
  a_write_code: assert property (port_q.st == cvd_pkg::ST_WR_END && quiet |=> common_voltage_code == $past(port_q.sh[7:1]) && port_q.sda_oe)
    else $error("written code not loaded or not acknowledged");
  a_write_both: assert property (port_q.st == cvd_pkg::ST_WR_END && quiet && !port_q.sh[0] |=> port_q.nv_req ##1 nv_busy)
    else $error("storage write not started");
  a_write_dac_only: assert property (port_q.st == cvd_pkg::ST_WR_END && quiet && port_q.sh[0] |=> !port_q.nv_req ##1 nv_code == $past(nv_code, 2))
    else $error("storage touched by volatile-only write");
  a_read_flag: assert property (port_q.st == cvd_pkg::ST_ACK_A && quiet && port_q.rw |=> port_q.sh[0] == ($past(port_q.dac) != $past(nv_code)))
    else $error("mismatch flag wrong");
  a_read_source: assert property (port_q.st == cvd_pkg::ST_ACK_A && quiet && port_q.rw |=> port_q.sh[7:1] == ($past(port_q.dac) != $past(nv_code) ? $past(port_q.dac) : $past(nv_code)) && port_q.sda_oe == !port_q.sh[7])
    else $error("read byte carries wrong source");
  a_read_one_byte: assert property (port_q.st == cvd_pkg::ST_RD && quiet && port_q.cnt == 3'h7 |=> port_q.st == cvd_pkg::ST_IGNORE && !port_q.sda_oe)
    else $error("more than one byte driven on read");
  a_drive_states: assert property (port_q.sda_oe |-> port_q.st inside {cvd_pkg::ST_ACK_A, cvd_pkg::ST_ACK_W, cvd_pkg::ST_RD})
    else $error("data line driven outside ack or read");
  a_boot_load: assert property (port_q.boot |=> !port_q.boot && common_voltage_code == $past(nv_code))
    else $error("reset load from storage missing");
  a_ack_release: assert property (port_q.st == cvd_pkg::ST_ACK_W && quiet |=>
    !port_q.sda_oe && port_q.st == cvd_pkg::ST_IGNORE)
    else $error("data acknowledge not released");
  a_refused_addr: assert property (port_q.st == cvd_pkg::ST_ADDR_END && quiet && !addr_hit |=>
    port_q.st == cvd_pkg::ST_IGNORE && !port_q.sda_oe)
    else $error("foreign address answered");
  a_start_restart: assert property (bus_start |=>
    port_q.st == cvd_pkg::ST_ADDR && port_q.cnt == 3'h0 && !port_q.sda_oe)
    else $error("start did not restart address phase");
  a_stop_idle: assert property (bus_stop |=>
    port_q.st == cvd_pkg::ST_IDLE && !port_q.sda_oe)
    else $error("stop did not return to idle");

  // ------------------------------------------------------------
  // Coverage
  // ------------------------------------------------------------
  c_write_dac: cover property (port_q.st == cvd_pkg::ST_WR_END && quiet && port_q.sh[0]);
  c_write_both: cover property (port_q.st == cvd_pkg::ST_WR_END && quiet && !port_q.sh[0]);
  c_read_diff: cover property (port_q.st == cvd_pkg::ST_RD && port_q.sh[0] && port_q.cnt == 3'h0);
  c_busy_skip: cover property (port_q.st == cvd_pkg::ST_ADDR_END && quiet && nv_busy && addr_hit);
  c_read_same: cover property (port_q.st == cvd_pkg::ST_RD && !port_q.sh[0] && port_q.cnt == 3'h0);

endmodule
`default_nettype wire

// [src/cvd_defines.svh]
// Offsets, field positions, reset values and timing counts for the common voltage port
// Operation
// - Bits 7..1 of the setting byte carry the 7-bit code, 00h to 7Fh.
// - Written byte with bit 0 low loads the DAC register and non-volatile copy.
// - Written byte with bit 0 high loads only the DAC register.
// - Read bit 0 is 1 when DAC register and non-volatile copy differ.
// - Device acknowledges its address and the single write data byte.
// - Read: address with read bit, device acks, sends one byte, master nacks.
// - Read returns DAC register when copies differ, else the non-volatile value.
// - Slave only; standard and fast bus rates supported.
// - While a write is in progress, addressing the device is ignored.
`ifndef CVD_DEFINES_SVH
`define CVD_DEFINES_SVH

`define CVD_SLAVE_ADDR    7'h4f
`define CVD_CODE_MSB      7
`define CVD_CODE_LSB      1
`define CVD_DEST_BIT      0
`define CVD_NV_RESET      7'h40
`define CVD_CLK_PERIOD_NS 4
`define CVD_NV_WRITE_NS   10000
`define CVD_NV_WRITE_CYC  ((`CVD_NV_WRITE_NS + `CVD_CLK_PERIOD_NS - 1) / `CVD_CLK_PERIOD_NS)
`define CVD_NV_CNT_W      12

`endif

// [src/cvd_pkg.sv]
// Types and shared decode for the common voltage port
package cvd_pkg;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_END,
    ST_ACK_A,
    ST_WR,
    ST_WR_END,
    ST_ACK_W,
    ST_RD,
    ST_IGNORE
  } cvd_state_e;

  typedef struct packed {
    cvd_state_e st;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic       rw;
    logic       sda_oe;
    logic       scl_q;
    logic       sda_q;
    logic [6:0] dac;
    logic       boot;
    logic       nv_req;
  } cvd_port_s;

  typedef struct packed {
    logic [6:0]  code;
    logic [6:0]  pend;
    logic [11:0] cnt;
    logic        busy;
  } cvd_nv_s;

  // Read byte: DAC value with flag 1 if copies differ, else stored value with flag 0
  function automatic logic [7:0] cvd_read_byte(input logic [6:0] dac, input logic [6:0] nv);
    cvd_read_byte = (dac != nv) ? {dac, 1'b1} : {nv, 1'b0};
  endfunction

endpackage

// [src/cvd_nv_store.sv]
// Non-volatile copy of the code with a timed write cycle
`timescale 1ns/100ps
`default_nettype none
`include "cvd_defines.svh"
module cvd_nv_store (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       wr_req,
  input  wire logic [6:0] wr_data,
  output logic      [6:0] nv_code,
  output logic            nv_busy
);

  localparam logic [11:0] WR_LAST = 12'(`CVD_NV_WRITE_CYC - 1);

  cvd_pkg::cvd_nv_s nv_q;
  cvd_pkg::cvd_nv_s nv_d;

  always_comb begin
    nv_d = nv_q;
    if (nv_q.busy) begin
      if (nv_q.cnt == 12'h000) begin
        nv_d.busy = 1'b0;
        nv_d.code = nv_q.pend;
      end else begin
        nv_d.cnt = nv_q.cnt - 12'h001;
      end
    end else if (wr_req) begin
      nv_d.busy = 1'b1;
      nv_d.pend = wr_data;
      nv_d.cnt  = WR_LAST;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      nv_q <= '{code: `CVD_NV_RESET, pend: `CVD_NV_RESET, cnt: 12'h000, busy: 1'b0};
    end else begin
      nv_q <= nv_d;
    end
  end

  assign nv_code = nv_q.code;
  assign nv_busy = nv_q.busy;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_nv_start_write: assert property (wr_req && !nv_q.busy |=> nv_q.busy && nv_q.cnt == WR_LAST)
    else $error("write request did not start the storage cycle");
  a_nv_commit_end: assert property (nv_q.busy && nv_q.cnt == 12'h000 |=> !nv_q.busy && nv_q.code == $past(nv_q.pend))
    else $error("storage write did not commit its data");

endmodule
`default_nettype wire

// [test/cvd_bus_master.sv]
// Two-wire bus master model for the common voltage port
`timescale 1ns/100ps
`default_nettype none
module cvd_bus_master (
  input  wire logic ref_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_low <= ~b;
    tick(3);
    scl <= 1'b1;
    tick(3);
    r = sda;
    scl <= 1'b0;
    tick(1);
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic start_cond();
    sda_low <= 1'b0;
    tick(1);
    scl <= 1'b1;
    tick(3);
    sda_low <= 1'b1;
    tick(3);
    scl <= 1'b0;
    tick(1);
  endtask
  task automatic stop_cond();
    sda_low <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(3);
    sda_low <= 1'b0;
    tick(4);
  endtask
  task automatic write_txn(input logic [7:0] a, input logic [7:0] d, output logic aa, output logic ad);
    start_cond();
    send_byte(a, aa);
    send_byte(d, ad);
    stop_cond();
  endtask
  // read one byte then no acknowledge
  task automatic read_txn(output logic aa, output logic [7:0] d);
    logic r;
    start_cond();
    send_byte(8'h9f, aa);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(1'b1, r);
    stop_cond();
  endtask
endmodule
`default_nettype wire

// [test/cvd_i2c_port_test.sv]
// Self-checking bench for the common voltage port
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
  $display("[ERR] t=%0t got %h exp %h", $time, got, exp); end end
module cvd_i2c_port_test;
  logic       ref_clk;
  logic       sys_rst;
  logic       scl;
  logic       sda_low;
  logic       sda_o;
  logic       sda_oe;
  logic [6:0] code;
  logic       busy;
  wire        sda = !((sda_oe && !sda_o) || sda_low);
  int         num_errors;
  int         checks_done;
  int         cycles;
  logic       aa;
  logic       ad;
  logic [7:0] rd;
  logic [7:0] vals [2] = '{8'h01, 8'hff};

  cvd_i2c_port u_dut (
    .ref_clk             (ref_clk),
    .sys_rst             (sys_rst),
    .scl_i               (scl),
    .sda_i               (sda),
    .sda_o               (sda_o),
    .sda_oe              (sda_oe),
    .common_voltage_code (code),
    .nv_write_busy       (busy)
  );
  cvd_bus_master u_mst (
    .ref_clk (ref_clk),
    .sda     (sda),
    .scl     (scl),
    .sda_low (sda_low)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      stop_test();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic exp);
    u_mst.write_txn(a, d, aa, ad);
    `CHK(aa, exp)
    `CHK(ad, exp)
  endtask
  task automatic rd_chk(input logic exp_ack, input logic [7:0] exp);
    u_mst.read_txn(aa, rd);
    `CHK(aa, exp_ack)
    if (exp_ack) `CHK(rd, exp)
  endtask

  initial begin
    sys_rst = 1'b1;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    `CHK(code, 7'h40)
    rd_chk(1'b1, 8'h80);
    wr(8'h9e, 8'hef, 1'b1);
    `CHK(code, 7'h77)
    `CHK(busy, 1'b0)
    rd_chk(1'b1, 8'hef);
    foreach (vals[i]) begin
      wr(8'h9e, vals[i], 1'b1);
      `CHK(code, vals[i][7:1])
      rd_chk(1'b1, vals[i]);
    end
    wr(8'h9e, 8'hee, 1'b1);
    `CHK(code, 7'h77)
    `CHK(busy, 1'b1)
    rd_chk(1'b0, 8'h00);
    wr(8'h9e, 8'h10, 1'b0);
    for (int n = 0; n < 3000 && busy !== 1'b0; n++) @(posedge ref_clk);
    `CHK(busy, 1'b0)
    `CHK(code, 7'h77)
    rd_chk(1'b1, 8'hee);
    wr(8'h9c, 8'h20, 1'b0);
    `CHK(code, 7'h77)
    stop_test();
  end
endmodule
`default_nettype wire
